//--- dpt_pkg.sv
// shared constants and types for the parallel tuning port
package dpt_pkg;
   localparam int unsigned FREQ_W        = 32;
   localparam int unsigned PHASE_W       = 5;
   localparam int unsigned CLK_HZ        = 25000000;
   // nominal internal master reference, millihertz
   localparam longint unsigned INT_REF_MHZ = 64'd28633115307;
   // tuning step 0.04 Hz expressed in units of 0.01 Hz
   localparam int unsigned STEP_CENTI_HZ = 4;
   // phase step 11.25 degrees in hundredths of a degree
   localparam int unsigned PHASE_STEP_CDEG = 1125;
   localparam int unsigned BUSY_CYCLES   = 8;
   localparam int unsigned UPDATE_CYCLES = 11;
   localparam int unsigned UPD_PULSE_NS  = 25;
   localparam int unsigned UPD_PULSE_CYC =
      ((UPD_PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000 < 1 ? 1 :
      ((UPD_PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000;
   localparam int unsigned INIT_MS       = 3000;
   localparam int unsigned INIT_CYCLES   = INIT_MS * (CLK_HZ / 1000);
   localparam int unsigned CLK_LOSS_CYCLES = 64;
   localparam logic [FREQ_W-1:0] NYQ_MAX = 32'h7FFFFFFF;
   typedef enum logic [1:0] {DPT_INIT, DPT_IDLE, DPT_BUSY, DPT_DOWN} dpt_state_t;
endpackage : dpt_pkg

//--- dpt_if.sv
// pin bundle joining host end and synthesizer end
interface dpt_if;
   import dpt_pkg::*;
   logic [FREQ_W-1:0]  freq_word;
   logic [PHASE_W-1:0] phase_word;
   logic               load_strobe_n;
   logic               busy_n;
   logic               ext_update;
   modport device (input freq_word, input phase_word, input load_strobe_n,
                   input ext_update, output busy_n);
   modport host   (output freq_word, output phase_word, output load_strobe_n,
                   output ext_update, input busy_n);
endinterface : dpt_if

//--- dpt_device.sv
// synthesizer end: strobe capture, busy timing, mode and clock supervision
// Behaviour
// - busy low until words transferred, 8 cycles
// - new settings in effect within 11 cycles
// - busy rises after 8 cycles, 3 cycles before words reach core
// - parallel mode does no error checking
// - mode jumper sampled only at power-up
// - lost master clock forces sticky power-down
// - serial reset command clears power-down
// - serial update pulse loads pending settings
// - host strobes all units together for phase
// - three second initialisation ignores commands
// - serial malformed command answers error code
// - frequency word unsigned, 0.04 Hz per step
// - host keeps frequency word below 2^31
// - host scales serial command for external clock
// - internal reference 28633115.3067 Hz nominal
// - clock select jumper chooses source
// - square-wave disable only in serial mode
// - phase offset equals N times 11.25 degrees
// - highest bus line is most significant
module dpt_device
   import dpt_pkg::*;
#(
   parameter int unsigned INIT_CYC = INIT_CYCLES,
   parameter int unsigned LOSS_CYC = CLK_LOSS_CYCLES
) (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   // link
   dpt_if.device                   link,
   // board straps and clock sources
   input  wire logic               mode_jumper_fitted_i,
   input  wire logic               clk_sel_ext_i,
   input  wire logic               int_clk_tick_i,
   input  wire logic               ext_clk_tick_i,
   // serial command interface results
   input  wire logic               ser_valid_i,
   input  wire logic               ser_bad_i,
   input  wire logic               ser_reset_i,
   input  wire logic [FREQ_W-1:0]  ser_freq_i,
   input  wire logic [PHASE_W-1:0] ser_phase_i,
   input  wire logic               ser_sq_en_i,
   // core side
   output logic [FREQ_W-1:0]       core_freq_o,
   output logic [PHASE_W-1:0]      core_phase_o,
   output logic                    sq_out_en_o,
   output logic                    serial_mode_o,
   output logic                    ext_clk_o,
   output logic                    power_down_o,
   output logic                    ready_o,
   output logic                    ser_err_o,
   output logic                    busy_n_o
);
   dpt_state_t        state_reg;
   logic [31:0]       init_cnt_reg;
   logic [31:0]       loss_cnt_reg;
   logic [3:0]        lat_cnt_reg;
   logic              strobe_q_reg;
   logic              upd_q_reg;
   logic              mode_taken_reg;
   logic [FREQ_W-1:0] cap_freq_reg;
   logic [PHASE_W-1:0] cap_phase_reg;
   logic [FREQ_W-1:0] pend_freq_reg;
   logic [PHASE_W-1:0] pend_phase_reg;
   logic              pend_sq_reg;
   logic              master_tick;
   logic              strobe_rise;
   logic              upd_rise;

   assign master_tick = clk_sel_ext_i ? ext_clk_tick_i : int_clk_tick_i;
   assign strobe_rise = link.load_strobe_n & ~strobe_q_reg;
   assign upd_rise    = link.ext_update & ~upd_q_reg;
   assign link.busy_n = busy_n_o;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strobe_q_reg <= 1'b1;
         upd_q_reg    <= 1'b0;
      end else begin
         strobe_q_reg <= link.load_strobe_n;
         upd_q_reg    <= link.ext_update;
      end
   end

   // mode strap caught once after reset release, never again; clock select followed every cycle
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_taken_reg <= 1'b0;
         serial_mode_o  <= 1'b0;
         ext_clk_o      <= 1'b0;
      end else begin
         if (!mode_taken_reg) begin
            mode_taken_reg <= 1'b1;
            serial_mode_o  <= mode_jumper_fitted_i;
         end
         ext_clk_o <= clk_sel_ext_i;
      end
   end

   // count system cycles since the last master tick
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         loss_cnt_reg <= '0;
      end else if (master_tick) begin
         loss_cnt_reg <= '0;
      end else if (loss_cnt_reg < LOSS_CYC) begin
         loss_cnt_reg <= loss_cnt_reg + 32'h00000001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_cnt_reg <= '0;
      end else if (state_reg == DPT_INIT) begin
         init_cnt_reg <= init_cnt_reg + 32'h00000001;
      end
   end

   // main sequencer; latency counted in master clock ticks
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg     <= DPT_INIT;
         lat_cnt_reg   <= '0;
         busy_n_o      <= 1'b1;
         cap_freq_reg  <= '0;
         cap_phase_reg <= '0;
         core_freq_o   <= '0;
         core_phase_o  <= '0;
         power_down_o  <= 1'b0;
         ready_o       <= 1'b0;
      end else if (loss_cnt_reg >= LOSS_CYC && state_reg != DPT_INIT) begin
         state_reg    <= DPT_DOWN;
         power_down_o <= 1'b1;
         busy_n_o     <= 1'b1;
         ready_o      <= 1'b0;
      end else begin
         unique case (state_reg)
            DPT_INIT: begin
               // strobes during start-up are dropped
               if (init_cnt_reg >= INIT_CYC - 1) begin
                  state_reg <= DPT_IDLE;
                  ready_o   <= 1'b1;
               end
            end
            DPT_IDLE: begin
               if (!serial_mode_o && strobe_rise) begin
                  // words taken unchecked, MSB on top line
                  cap_freq_reg  <= link.freq_word;
                  cap_phase_reg <= link.phase_word;
                  busy_n_o      <= 1'b0;
                  lat_cnt_reg   <= '0;
                  state_reg     <= DPT_BUSY;
               end else if (serial_mode_o && upd_rise) begin
                  core_freq_o  <= pend_freq_reg;
                  core_phase_o <= pend_phase_reg;
               end
            end
            DPT_BUSY: begin
               if (master_tick) begin
                  lat_cnt_reg <= lat_cnt_reg + 4'h1;
                  if (lat_cnt_reg == 4'(BUSY_CYCLES - 1)) begin
                     busy_n_o <= 1'b1;
                  end
                  if (lat_cnt_reg == 4'(UPDATE_CYCLES - 1)) begin
                     core_freq_o  <= cap_freq_reg;
                     core_phase_o <= cap_phase_reg;
                     state_reg    <= DPT_IDLE;
                  end
               end
            end
            DPT_DOWN: begin
               if (serial_mode_o && ser_reset_i) begin
                  state_reg    <= DPT_IDLE;
                  power_down_o <= 1'b0;
                  ready_o      <= 1'b1;
               end
            end
         endcase
      end
   end

   // serial frequency and phase wait here until the update pulse; square-wave enable follows at once
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_freq_reg  <= '0;
         pend_phase_reg <= '0;
         pend_sq_reg    <= 1'b1;
         sq_out_en_o    <= 1'b1;
         ser_err_o      <= 1'b0;
      end else begin
         ser_err_o <= 1'b0;
         if (serial_mode_o && ready_o && ser_valid_i) begin
            if (ser_bad_i) begin
               ser_err_o <= 1'b1;
            end else begin
               pend_freq_reg  <= ser_freq_i;
               pend_phase_reg <= ser_phase_i;
               pend_sq_reg    <= ser_sq_en_i;
            end
         end
         // parallel mode cannot switch the square wave off
         sq_out_en_o <= serial_mode_o ? pend_sq_reg : 1'b1;
      end
   end
endmodule : dpt_device

//--- dpt_host.sv
// host end: presents words, strobes load, waits for busy release
module dpt_host
   import dpt_pkg::*;
(
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   // user request
   input  wire logic               req_i,
   input  wire logic [FREQ_W-1:0]  freq_i,
   input  wire logic [PHASE_W-1:0] phase_i,
   input  wire logic               upd_req_i,
   output logic                    done_o,
   output logic                    idle_o,
   // link
   dpt_if.host                     link
);
   typedef enum logic [2:0] {DPTH_IDLE, DPTH_SETUP, DPTH_LOW, DPTH_WAIT, DPTH_UPD} dpth_state_t;
   dpth_state_t        state_reg;
   logic [FREQ_W-1:0]  freq_reg;
   logic [PHASE_W-1:0] phase_reg;
   logic               strobe_n_reg;
   logic               upd_reg;
   logic [3:0]         cnt_reg;

   assign link.freq_word     = freq_reg;
   assign link.phase_word    = phase_reg;
   assign link.load_strobe_n = strobe_n_reg;
   assign link.ext_update    = upd_reg;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg    <= DPTH_IDLE;
         freq_reg     <= '0;
         phase_reg    <= '0;
         strobe_n_reg <= 1'b1;
         upd_reg      <= 1'b0;
         cnt_reg      <= '0;
         done_o       <= 1'b0;
         idle_o       <= 1'b1;
      end else begin
         done_o <= 1'b0;
         unique case (state_reg)
            DPTH_IDLE: begin
               if (req_i) begin
                  // clamp keeps the word under the Nyquist limit
                  freq_reg  <= (freq_i > NYQ_MAX) ? NYQ_MAX : freq_i;
                  phase_reg <= phase_i;
                  idle_o    <= 1'b0;
                  state_reg <= DPTH_SETUP;
               end else if (upd_req_i) begin
                  upd_reg   <= 1'b1;
                  cnt_reg   <= '0;
                  idle_o    <= 1'b0;
                  state_reg <= DPTH_UPD;
               end
            end
            DPTH_SETUP: begin
               strobe_n_reg <= 1'b0; // data stable one cycle (40 ns) before
               state_reg    <= DPTH_LOW;
            end
            DPTH_LOW: begin
               strobe_n_reg <= 1'b1;
               state_reg    <= DPTH_WAIT;
            end
            DPTH_WAIT: begin
               // words held until busy clears, covering hold time
               if (link.busy_n && cnt_reg != 4'h0) begin
                  done_o    <= 1'b1;
                  idle_o    <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= DPTH_IDLE;
               end else if (!link.busy_n) begin
                  cnt_reg <= 4'h1;
               end
            end
            DPTH_UPD: begin
               if (cnt_reg == 4'(UPD_PULSE_CYC - 1)) begin
                  upd_reg   <= 1'b0;
                  done_o    <= 1'b1;
                  idle_o    <= 1'b1;
                  state_reg <= DPTH_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: state_reg <= DPTH_IDLE;
         endcase
      end
   end
endmodule : dpt_host

//--- dpt_sva.sv
// interface-level checks on the link between host end and synthesizer end
module dpt_sva
   import dpt_pkg::*;
(
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   input  wire logic [FREQ_W-1:0]  freq_word,
   input  wire logic [PHASE_W-1:0] phase_word,
   input  wire logic               load_strobe_n,
   input  wire logic               busy_n,
   input  wire logic               ext_update
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   // busy timing assumes one master tick per clock while a load is running
   a_busy_on_strobe: assert property ($rose(load_strobe_n) && busy_n |=> !busy_n)
      else $error("busy not asserted after strobe");
   a_busy_cause: assert property ($fell(busy_n) |-> $past(load_strobe_n) &&
      !$past(load_strobe_n, 2)) else $error("busy asserted without strobe");
   a_busy_min_len: assert property ($fell(busy_n) |=> !busy_n [*7])
      else $error("busy released early");
   a_busy_max_len: assert property ($fell(busy_n) |-> ##[1:8] busy_n)
      else $error("busy held too long");
   a_no_strobe_busy: assert property (!busy_n |-> load_strobe_n)
      else $error("strobe while busy");
   a_words_stable: assert property (!load_strobe_n |-> $stable(freq_word) &&
      $stable(phase_word)) else $error("words moved under strobe");
   a_update_pulse: assert property ($rose(ext_update) |=> !ext_update)
      else $error("update pulse length wrong");
   a_freq_range: assert property (!load_strobe_n |-> !freq_word[FREQ_W-1])
      else $error("frequency word above limit");
endmodule : dpt_sva

//--- tb_top.sv
// self-checking bench: host end and synthesizer end joined by the link
module tb_top
   import dpt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic               sys_clk, resetn, req, upd, idle, bsy, dn;
   logic               mjmp, cext, itk, etk, sv, sb, sr, sq;
   logic               sqo, smo, exo, pdo, rdy, serr;
   logic [FREQ_W-1:0]  fi, sf, cf;
   logic [PHASE_W-1:0] pi, sp, cp;
   int                 n_mismatch, n_tests, h;
   dpt_if lnk ();
   // short init and loss counts keep the run brief
   dpt_device #(.INIT_CYC(20), .LOSS_CYC(16)) i_dpt_device (
      .sys_clk_i(sys_clk), .resetn_i(resetn), .link(lnk.device),
      .mode_jumper_fitted_i(mjmp), .clk_sel_ext_i(cext), .int_clk_tick_i(itk),
      .ext_clk_tick_i(etk), .ser_valid_i(sv), .ser_bad_i(sb), .ser_reset_i(sr),
      .ser_freq_i(sf), .ser_phase_i(sp), .ser_sq_en_i(sq), .core_freq_o(cf),
      .core_phase_o(cp), .sq_out_en_o(sqo), .serial_mode_o(smo), .ext_clk_o(exo),
      .power_down_o(pdo), .ready_o(rdy), .ser_err_o(serr), .busy_n_o(bsy));
   dpt_host i_dpt_host (.sys_clk_i(sys_clk), .resetn_i(resetn), .req_i(req),
      .freq_i(fi), .phase_i(pi), .upd_req_i(upd), .done_o(dn), .idle_o(idle),
      .link(lnk.host));
   dpt_sva i_dpt_sva (.sys_clk_i(sys_clk), .resetn_i(resetn), .freq_word(lnk.freq_word),
      .phase_word(lnk.phase_word), .load_strobe_n(lnk.load_strobe_n),
      .busy_n(lnk.busy_n), .ext_update(lnk.ext_update));
   initial begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [FREQ_W-1:0] seen, exp, input string m);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic wt(ref logic s, input logic v, input int lim);
      int k;
      k = 0;
      while (s !== v) begin
         @(negedge sys_clk);
         k++;
         if (k > lim) begin
            chk(0, 1, "wait timed out");
            complete_run();
         end
      end
   endtask : wt
   // a one-cycle error pulse is easy to miss, so count it over a short span
   task automatic cnt_err;
      h = 0;
      // sample first: the pulse may already stand when the strobe task returns
      repeat (4) begin
         h += (serr === 1'b1);
         @(negedge sys_clk);
      end
   endtask : cnt_err
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge sys_clk);
      s = 0;
   endtask : pulse
   task automatic do_reset;
      resetn = 0;
      repeat (8) @(negedge sys_clk);
      resetn = 1;
      repeat (10) @(negedge sys_clk);
      chk(rdy, 0, "ready during init");
      wt(rdy, 1, 40);
   endtask : do_reset
   task automatic ld(input logic [FREQ_W-1:0] f, exf, input logic [PHASE_W-1:0] p);
      int n;
      fi = f;
      pi = p;
      pulse(req);
      wt(bsy, 0, 10);
      n = 0;
      while (bsy === 1'b0 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n, 8, "busy length");
      @(negedge sys_clk);
      chk(dn, 1, "host done after busy release");
      repeat (2) @(negedge sys_clk);
      chk(cf, exf, "core frequency");
      chk(cp, p, "core phase");
      wt(idle, 1, 10);
   endtask : ld
   task automatic par_loads;
      chk(smo, 0, "parallel mode");
      chk(exo, 0, "internal clock");
      ld(32'h12345678, 32'h12345678, 5'h03);
      ld(32'h40000001, 32'h40000001, 5'h10);
      ld(32'hFFFFFFFF, 32'h7FFFFFFF, 5'h1F);
   endtask : par_loads
   task automatic par_noerr;
      sf = 32'h00000ABC;
      sb = 1;
      sq = 0;
      pulse(sv);
      cnt_err();
      chk(h, 0, "error reported in parallel");
      pulse(upd);
      repeat (4) @(negedge sys_clk);
      chk(cf, 32'h7FFFFFFF, "serial data taken in parallel");
      chk(sqo, 1, "square wave disabled in parallel");
   endtask : par_noerr
   task automatic lose_clk(input logic exp_after);
      itk = 0;
      etk = 0;
      repeat (12) @(negedge sys_clk);
      chk(pdo, 0, "early power down");
      repeat (8) @(negedge sys_clk);
      chk(pdo, 1, "no power down");
      itk = 1;
      etk = 1;
      repeat (4) @(negedge sys_clk);
      pulse(sr);
      repeat (4) @(negedge sys_clk);
      chk(pdo, exp_after, "power down after reset command");
   endtask : lose_clk
   task automatic ser_mode;
      mjmp = 1;
      cext = 1;
      do_reset();
      mjmp = 0;
      @(negedge sys_clk);
      chk(smo, 1, "serial mode");
      chk(exo, 1, "external clock");
      cnt_err();
      chk(smo, 1, "mode strap resampled");
      sb = 1;
      pulse(sv);
      cnt_err();
      chk(h, 1, "bad command not flagged");
      sb = 0;
      sf = 32'h00ABCDEF;
      sp = 5'h07;
      pulse(sv);
      cnt_err();
      chk(h, 0, "good command flagged");
      chk(cf, 0, "core moved before update");
      pulse(upd);
      repeat (4) @(negedge sys_clk);
      chk(cf, 32'h00ABCDEF, "serial frequency");
      chk(cp, 5'h07, "serial phase");
      chk(sqo, 0, "square wave disable");
      lose_clk(1'b0);
   endtask : ser_mode
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      resetn = 0;
      {req, upd, mjmp, cext, sv, sb, sr} = '0;
      {itk, etk, sq} = 3'h7;
      fi = '0;
      pi = '0;
      sf = '0;
      sp = '0;
      do_reset();
      par_loads();
      par_noerr();
      lose_clk(1'b1);
      ser_mode();
      complete_run();
   end
endmodule : tb_top
